// ===== jtp_ctl_model.sv
/*
 * far end model: a test controller clocking tck only inside frames.
 * assumes the device drives tdo only while its enable is high.
 */
`timescale 1ns/1ps

module jtp_ctl_model (
    // pins toward the device
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    // pins from the device
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    logic pin; // resolved tdo wire, no pull on it

    // idle levels match the internal pull-ups
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        pin = 1'b0;
    end

    // one period; pins change after falling tck, tdo taken at rising
    task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
        tms_o = tms;
        tdi_o = tdi;
        #62.5 tck_o = 1'b1;
        pin = tdo_oe_i ? tdo_i : ~pin; // released wire floats, seen as flipping
        tdo = pin;
        oe = tdo_oe_i;
        #62.5 tck_o = 1'b0;
    endtask

    // tms bits lsb first, tdi low
    task automatic walk(input logic [7:0] tms, input int n);
        logic t, e;
        for (int i = 0; i < n; i++) tick(tms[i], 1'b0, t, e);
    endtask

    // entry, n bits lsb first with tms high on the last, then update
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
        input logic idle, output logic [31:0] dout, output logic oe_ok);
        logic t, e;
        dout = '0;
        oe_ok = 1'b1;
        walk(ir ? 8'b0011 : 8'b001, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], t, e);
            dout[i] = t;
            oe_ok &= e;
        end
        walk(idle ? 8'b01 : 8'b1, idle ? 2 : 1);
    endtask
endmodule

// ===== jtp_params.svh
/*
 * constants of the test access port: instruction codes, capture value,
 * widths and reset values.
 * assumes it is included by bare name by every file that needs a figure.
 */
// Overview of operation
// [RL1] sixteen states stepped by tms on rising tck
// [RL2] power-on reset starts in test-logic-reset
// [RL3] every shift path moves lsb first
// [RL4] from idle, tms 1,1,0,0 reaches shift-ir
// [RL5] four-bit instruction, tms high with top bit
// [RL6] instruction shift presents captured 0x01 on tdo
// [RL7] instruction picks exactly one data path
// [RL8] 1,1,0 returns idle; instruction applies at update-ir
// [RL9] from idle, tms 1,0,0 reaches shift-dr
// [RL10] shift-dr presents values taken in capture-dr
// [RL11] latched data output changes only at update-dr
// [RL12] exit, pause states only navigate, no effects
// [RL13] update may go straight to dr scan
// [RL14] five tms-high edges reach test-logic-reset
// [RL15] no test reset pin; tms or power-on only
// [RL16] fuse off: port pins, tap held reset
// [RL17] fuse programmed by default, port active
// [RL18] board-test paths public; debug chains not reachable
// [RL19] all tap activity on test clock
// [RL20] debugger watches and may pull system reset
// [RL21] tdo changes on falling tck, only while shifting
// [RL22] unlisted moves follow standard transition table
`ifndef JTP_PARAMS_SVH
`define JTP_PARAMS_SVH

// instruction register
`define JTP_IR_WIDTH 4
`define JTP_IR_CAPTURE 4'h1
`define JTP_OP_IDCODE 4'h1
`define JTP_OP_USERDR 4'h2
`define JTP_OP_BYPASS 4'hF

// data paths
`define JTP_ID_WIDTH 32
`define JTP_USR_WIDTH 8
`define JTP_BYPASS_CAPTURE 1'h0
`define JTP_USR_RESET 8'h00

// fuse level that means programmed
`define JTP_FUSE_ON 1'h1

`endif

// ===== jtp_pkg.sv
/*
 * types of the test access port: the controller state encoding.
 * assumes nothing beyond a systemverilog compiler.
 */
package jtp_pkg;

    // controller states, binary codes fixed
    typedef enum logic [3:0] {
        JTP_TLR       = 4'h0,
        JTP_IDLE      = 4'h1,
        JTP_SEL_DR    = 4'h2,
        JTP_CAP_DR    = 4'h3,
        JTP_SHIFT_DR  = 4'h4,
        JTP_EXIT1_DR  = 4'h5,
        JTP_PAUSE_DR  = 4'h6,
        JTP_EXIT2_DR  = 4'h7,
        JTP_UPD_DR    = 4'h8,
        JTP_SEL_IR    = 4'h9,
        JTP_CAP_IR    = 4'hA,
        JTP_SHIFT_IR  = 4'hB,
        JTP_EXIT1_IR  = 4'hC,
        JTP_PAUSE_IR  = 4'hD,
        JTP_EXIT2_IR  = 4'hE,
        JTP_UPD_IR    = 4'hF
    } jtp_state_t;

endpackage

// ===== jtp_sync2.sv
/*
 * two flip-flop synchroniser, one per bit.
 * assumes each bit is a level or a slow toggle; words are not
 * coherent through it and need a handshake around it.
 */
`timescale 1ns/1ps

module jtp_sync2 #(
    parameter int WIDTH = 1
) (
    // destination clock
    input  wire logic clk_i,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    // first stage is read only by the second stage
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge clk_i) begin
                meta_ff <= d_i[gi];
                sync_ff <= meta_ff;
            end
            assign q_o[gi] = sync_ff;
        end
    endgenerate

endmodule

// ===== jtp_tap.sv
/*
 * test access port: sixteen-state controller, instruction register,
 * identification, bypass and a user data register with a latched
 * output handed to the core clock domain.
 * assumes tms and tdi are launched by the far end relative to tck,
 * the fuse is a static level, and nrst_i is the power-on reset in
 * the core clock domain.
 */
`timescale 1ns/1ps
`include "jtp_params.svh"

module jtp_tap
    import jtp_pkg::*;
#(
    parameter logic [`JTP_ID_WIDTH-1:0] ID_CODE = 32'h0000_0001, // arbitrary value
    parameter int USR_WIDTH = `JTP_USR_WIDTH
) (
    // core clock and reset
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    // test port pins, all on the test clock
    input  wire logic tck_i,
    input  wire logic tms_i,
    input  wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // enable fuse and pin control
    input  wire logic test_port_enable_fuse_i,
    output logic pullup_en_o,
    output logic port_mode_o,
    // core side view of the port
    output logic [`JTP_IR_WIDTH-1:0] instr_o,
    output logic [USR_WIDTH-1:0] user_data_o,
    output logic user_update_o,
    output logic run_idle_o,
    output logic tap_reset_o
);

    localparam int IRW = `JTP_IR_WIDTH;
    localparam int IDW = `JTP_ID_WIDTH;

    // test clock domain state
    jtp_state_t state_ff;
    jtp_state_t nxt_state;
    logic [IRW-1:0] ir_shift_ff;
    logic [IRW-1:0] ir_active_ff;
    logic [IDW-1:0] id_shift_ff;
    logic bypass_ff;
    logic [USR_WIDTH-1:0] usr_shift_ff;
    logic [USR_WIDTH-1:0] usr_upd_ff;
    logic usr_tgl_ff;
    logic ir_tgl_ff;
    logic tdo_ff;
    logic tdo_oe_ff;

    // core clock domain state
    logic fuse_core;
    logic tgl_core_usr;
    logic tgl_core_ir;
    logic usr_tgl_seen_ff;
    logic ir_tgl_seen_ff;
    logic [IRW-1:0] instr_ff;
    logic [USR_WIDTH-1:0] user_data_ff;
    logic user_update_ff;
    logic run_idle_core;
    logic tlr_core;
    logic run_idle_ff;
    logic tap_reset_ff;
    logic pullup_en_ff;
    logic port_mode_ff;
    logic idle_flag_ff;
    logic tlr_flag_ff;

    // reset and fuse brought into the test clock domain
    logic por_n_tck;
    logic fuse_tck;
    logic tap_hold;

    // power-on reset and the fuse-off hold are the only sources besides the tms sequence;
    // there is no test reset pin on this port
    jtp_sync2 #(
        .WIDTH(2)
    ) u_sync_tck (
        .clk_i(tck_i),
        .d_i({nrst_i, test_port_enable_fuse_i}),
        .q_o({por_n_tck, fuse_tck})
    );

    // controller held in reset while the fuse is off
    assign tap_hold = !por_n_tck || (fuse_tck != `JTP_FUSE_ON); // RL15 RL16

    // state decode
    logic st_tlr;
    logic st_cap_ir;
    logic st_shift_ir;
    logic st_upd_ir;
    logic st_cap_dr;
    logic st_shift_dr;
    logic st_upd_dr;
    assign st_tlr = (state_ff == JTP_TLR);
    assign st_cap_ir = (state_ff == JTP_CAP_IR);
    assign st_shift_ir = (state_ff == JTP_SHIFT_IR);
    assign st_upd_ir = (state_ff == JTP_UPD_IR);
    assign st_cap_dr = (state_ff == JTP_CAP_DR);
    assign st_shift_dr = (state_ff == JTP_SHIFT_DR);
    assign st_upd_dr = (state_ff == JTP_UPD_DR);

    // instruction decode: one path at a time, unknown codes go to bypass;
    // the private debug chain codes therefore reach nothing here
    logic sel_id;
    logic sel_usr;
    logic sel_byp;
    assign sel_id = (ir_active_ff == `JTP_OP_IDCODE); // RL7
    assign sel_usr = (ir_active_ff == `JTP_OP_USERDR); // RL7
    assign sel_byp = !sel_id && !sel_usr; // RL7 RL18

    // next state table, stepped by tms on each rising tck
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            JTP_TLR:      nxt_state = tms_i ? JTP_TLR : JTP_IDLE; // RL1 RL14
            JTP_IDLE:     nxt_state = tms_i ? JTP_SEL_DR : JTP_IDLE; // RL4 RL9
            JTP_SEL_DR:   nxt_state = tms_i ? JTP_SEL_IR : JTP_CAP_DR; // RL4 RL9
            JTP_CAP_DR:   nxt_state = tms_i ? JTP_EXIT1_DR : JTP_SHIFT_DR; // RL9
            JTP_SHIFT_DR: nxt_state = tms_i ? JTP_EXIT1_DR : JTP_SHIFT_DR; // RL10
            JTP_EXIT1_DR: nxt_state = tms_i ? JTP_UPD_DR : JTP_PAUSE_DR; // RL22
            JTP_PAUSE_DR: nxt_state = tms_i ? JTP_EXIT2_DR : JTP_PAUSE_DR; // RL22
            JTP_EXIT2_DR: nxt_state = tms_i ? JTP_UPD_DR : JTP_SHIFT_DR; // RL22
            JTP_UPD_DR:   nxt_state = tms_i ? JTP_SEL_DR : JTP_IDLE; // RL8 RL13
            JTP_SEL_IR:   nxt_state = tms_i ? JTP_TLR : JTP_CAP_IR; // RL4 RL14
            JTP_CAP_IR:   nxt_state = tms_i ? JTP_EXIT1_IR : JTP_SHIFT_IR; // RL4
            JTP_SHIFT_IR: nxt_state = tms_i ? JTP_EXIT1_IR : JTP_SHIFT_IR; // RL5
            JTP_EXIT1_IR: nxt_state = tms_i ? JTP_UPD_IR : JTP_PAUSE_IR; // RL8
            JTP_PAUSE_IR: nxt_state = tms_i ? JTP_EXIT2_IR : JTP_PAUSE_IR; // RL22
            JTP_EXIT2_IR: nxt_state = tms_i ? JTP_UPD_IR : JTP_SHIFT_IR; // RL22
            JTP_UPD_IR:   nxt_state = tms_i ? JTP_SEL_DR : JTP_IDLE; // RL8 RL13
        endcase
    end

    // controller register; five tms-high edges reach reset from anywhere
    always_ff @(posedge tck_i) begin // RL19
        if (tap_hold) begin
            state_ff <= JTP_TLR; // RL2
        end else begin
            state_ff <= nxt_state; // RL1
        end
    end

    // instruction shift path: capture fixed pattern, lsb out first
    logic [IRW-1:0] nxt_ir_shift;
    assign nxt_ir_shift = st_cap_ir ? `JTP_IR_CAPTURE : // RL6
        st_shift_ir ? {tdi_i, ir_shift_ff[IRW-1:1]} : // RL3 RL5
        ir_shift_ff; // RL12

    always_ff @(posedge tck_i) begin
        if (tap_hold) begin
            ir_shift_ff <= `JTP_IR_CAPTURE;
        end else begin
            ir_shift_ff <= nxt_ir_shift;
        end
    end

    // entering test-logic-reset restores idcode at that very edge, so the
    // core sees it as soon as the five tms highs are done
    logic ir_to_id;
    assign ir_to_id = tap_hold || (nxt_state == JTP_TLR); // RL14

    // active instruction: idcode after reset, new code only at update-ir
    always_ff @(posedge tck_i) begin
        if (ir_to_id) begin
            ir_active_ff <= `JTP_OP_IDCODE;
        end else if (st_upd_ir) begin
            ir_active_ff <= ir_shift_ff; // RL8
        end
    end

    // identification path
    logic [IDW-1:0] nxt_id_shift;
    assign nxt_id_shift = (st_cap_dr && sel_id) ? ID_CODE : // RL10
        (st_shift_dr && sel_id) ? {tdi_i, id_shift_ff[IDW-1:1]} : // RL3
        id_shift_ff; // RL12

    always_ff @(posedge tck_i) begin
        if (tap_hold) begin
            id_shift_ff <= ID_CODE;
        end else begin
            id_shift_ff <= nxt_id_shift;
        end
    end

    // bypass path, one stage
    logic nxt_bypass;
    assign nxt_bypass = (st_cap_dr && sel_byp) ? `JTP_BYPASS_CAPTURE : // RL10
        (st_shift_dr && sel_byp) ? tdi_i : // RL3
        bypass_ff;

    always_ff @(posedge tck_i) begin
        if (tap_hold) begin
            bypass_ff <= `JTP_BYPASS_CAPTURE;
        end else begin
            bypass_ff <= nxt_bypass;
        end
    end

    // user path captures its own latched output, so a scan reads back
    // what was last written without any word crossing from the core
    logic [USR_WIDTH-1:0] nxt_usr_shift;
    assign nxt_usr_shift = (st_cap_dr && sel_usr) ? usr_upd_ff : // RL10
        (st_shift_dr && sel_usr) ? {tdi_i, usr_shift_ff[USR_WIDTH-1:1]} : // RL3
        usr_shift_ff; // RL12

    always_ff @(posedge tck_i) begin
        if (tap_hold) begin
            usr_shift_ff <= USR_WIDTH'(`JTP_USR_RESET);
        end else begin
            usr_shift_ff <= nxt_usr_shift;
        end
    end

    // latched user output changes only at update-dr; toggles announce it
    logic usr_latch;
    assign usr_latch = st_upd_dr && sel_usr && !tap_hold; // RL16

    // only power-on clears the word, so the core copy never drifts from it
    always_ff @(posedge tck_i) begin
        if (!por_n_tck) begin
            usr_upd_ff <= USR_WIDTH'(`JTP_USR_RESET);
            usr_tgl_ff <= 1'h0;
        end else if (usr_latch) begin
            usr_upd_ff <= usr_shift_ff; // RL11
            usr_tgl_ff <= !usr_tgl_ff;
        end
    end

    // toggle on each instruction change so the core can copy the code;
    // a fuse-off hold that restores idcode is announced as well
    logic ir_moved;
    assign ir_moved = ir_to_id ? (ir_active_ff != `JTP_OP_IDCODE) : st_upd_ir;

    always_ff @(posedge tck_i) begin
        if (!por_n_tck) begin
            ir_tgl_ff <= 1'h0;
        end else if (ir_moved) begin
            ir_tgl_ff <= !ir_tgl_ff;
        end
    end

    // serial output select for the falling edge
    logic tdo_sel;
    logic tdo_drive;
    assign tdo_sel = st_shift_ir ? ir_shift_ff[0] : // RL3 RL6
        sel_id ? id_shift_ff[0] :
        sel_usr ? usr_shift_ff[0] :
        bypass_ff; // RL7
    assign tdo_drive = st_shift_ir || st_shift_dr; // RL21

    // falling edge launch gives the far end half a period of hold;
    // a released pin parks low
    always_ff @(negedge tck_i) begin
        if (tap_hold) begin
            tdo_ff <= 1'h0;
            tdo_oe_ff <= 1'h0;
        end else begin
            tdo_ff <= tdo_drive ? tdo_sel : 1'h0; // RL21
            tdo_oe_ff <= tdo_drive; // RL21
        end
    end

    assign tdo_o = tdo_ff;
    assign tdo_oe_o = tdo_oe_ff;

    // levels of interest to the core, registered from the next state so
    // a decode glitch never reaches the synchroniser
    always_ff @(posedge tck_i) begin
        if (tap_hold) begin
            idle_flag_ff <= 1'h0;
            tlr_flag_ff <= 1'h1;
        end else begin
            idle_flag_ff <= (nxt_state == JTP_IDLE); // RL13
            tlr_flag_ff <= (nxt_state == JTP_TLR); // RL14
        end
    end

    // test clock levels and toggles, and the fuse, into the core domain; tck may stop,
    // so the tck levels freeze at their last value until the next frame
    jtp_sync2 #(
        .WIDTH(5)
    ) u_sync_core (
        .clk_i(core_clk_i),
        .d_i({test_port_enable_fuse_i, usr_tgl_ff, ir_tgl_ff, idle_flag_ff, tlr_flag_ff}),
        .q_o({fuse_core, tgl_core_usr, tgl_core_ir, run_idle_core, tlr_core})
    );

    // a toggle flips at the same tck edge as the word behind it and arrives two
    // synchroniser stages later, so copying the word on the core clock is safe
    logic usr_new;
    logic ir_new;
    assign usr_new = (tgl_core_usr != usr_tgl_seen_ff);
    assign ir_new = (tgl_core_ir != ir_tgl_seen_ff);

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            usr_tgl_seen_ff <= 1'h0;
            ir_tgl_seen_ff <= 1'h0;
        end else begin
            usr_tgl_seen_ff <= tgl_core_usr;
            ir_tgl_seen_ff <= tgl_core_ir;
        end
    end

    // core copy of the latched user word with a one-cycle strobe
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            user_data_ff <= USR_WIDTH'(`JTP_USR_RESET);
            user_update_ff <= 1'h0;
        end else begin
            user_update_ff <= usr_new;
            if (usr_new) begin
                user_data_ff <= usr_upd_ff; // RL11
            end
        end
    end

    // core copy of the active instruction
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            instr_ff <= `JTP_OP_IDCODE;
        end else if (ir_new) begin
            instr_ff <= ir_active_ff; // RL8
        end
    end

    // controller status and pin control, registered in the core domain
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            run_idle_ff <= 1'h0;
            tap_reset_ff <= 1'h1;
            pullup_en_ff <= 1'h0;
            port_mode_ff <= 1'h1;
        end else begin
            run_idle_ff <= run_idle_core;
            tap_reset_ff <= tlr_core;
            pullup_en_ff <= (fuse_core == `JTP_FUSE_ON); // RL16 RL17
            port_mode_ff <= (fuse_core != `JTP_FUSE_ON); // RL16
        end
    end

    assign user_data_o = user_data_ff;
    assign user_update_o = user_update_ff;
    assign instr_o = instr_ff;
    assign run_idle_o = run_idle_ff;
    assign tap_reset_o = tap_reset_ff;
    assign pullup_en_o = pullup_en_ff;
    assign port_mode_o = port_mode_ff;

endmodule

// ===== jtp_tap_sva.sv
/*
 * assertions on the test port pins and the core side outputs.
 * assumes it is bound to jtp_tap and the fuse only moves while idle.
 */
`timescale 1ns/1ps
`include "jtp_params.svh"

module jtp_tap_sva #(
    parameter int USR_WIDTH = 8
) (
    // clocks and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic tck_i,
    // pins and fuse
    input wire logic tms_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic test_port_enable_fuse_i,
    // core side
    input wire logic pullup_en_o,
    input wire logic port_mode_o,
    input wire logic [`JTP_IR_WIDTH-1:0] instr_o,
    input wire logic [USR_WIDTH-1:0] user_data_o,
    input wire logic user_update_o,
    input wire logic run_idle_o,
    input wire logic tap_reset_o
);
    // scan entry walks from idle; run_idle_o lags well under one tck
    // period, so it still shows idle at the edge that leaves it
    sequence s_idle;
        run_idle_o && tms_i;
    endsequence
    sequence s_to_ir;
        s_idle ##1 tms_i ##1 !tms_i ##1 !tms_i;
    endsequence
    sequence s_to_dr;
        s_idle ##1 !tms_i ##1 !tms_i;
    endsequence

    AST_IR_ENTRY: assert property (@(posedge tck_i) disable iff (!nrst_i)
        s_to_ir |=> tdo_oe_o && tdo_o) else $error("ir capture bit missing");
    AST_DR_ENTRY: assert property (@(posedge tck_i) disable iff (!nrst_i)
        s_to_dr |=> tdo_oe_o) else $error("dr shift not entered");
    AST_OE_EXIT: assert property (@(posedge tck_i) disable iff (!nrst_i)
        tdo_oe_o && tms_i |=> !tdo_oe_o) else $error("tdo still driven after shift");
    AST_TLR: assert property (@(posedge tck_i) disable iff (!nrst_i)
        tms_i [*5] |=> tap_reset_o && instr_o == `JTP_OP_IDCODE)
        else $error("five tms highs did not reset");
    AST_TDO_FALL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        $changed(tdo_o) || $changed(tdo_oe_o) |-> !tck_i)
        else $error("tdo moved outside tck low phase");
    AST_TDO_IDLE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !tdo_oe_o |-> !tdo_o) else $error("tdo high while released");
    AST_UPD_DATA: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !$stable(user_data_o) |-> user_update_o) else $error("user data moved silently");
    AST_UPD_PULSE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        user_update_o |=> !user_update_o) else $error("update pulse too long");
    AST_FUSE_OFF: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !test_port_enable_fuse_i [*6] |-> port_mode_o && !pullup_en_o)
        else $error("fuse off but port active");
    AST_FUSE_ON: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        test_port_enable_fuse_i [*6] |-> pullup_en_o && !port_mode_o)
        else $error("fuse on but port inactive");
endmodule

bind jtp_tap jtp_tap_sva #(.USR_WIDTH(USR_WIDTH)) u_sva (.core_clk_i, .nrst_i, .tck_i,
    .tms_i, .tdo_o, .tdo_oe_o, .test_port_enable_fuse_i, .pullup_en_o, .port_mode_o,
    .instr_o, .user_data_o, .user_update_o, .run_idle_o, .tap_reset_o);

// ===== testbench.sv
/*
 * self-checking bench for jtp_tap with a controller model on the pins.
 * assumes core outputs settle within eight core cycles of a tck edge.
 */
`timescale 1ns/1ps
`include "jtp_params.svh"

module testbench;
    localparam logic [31:0] ID = 32'h5A3C_0F01; // arbitrary value
    logic core_clk_i, nrst_i, fuse, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o;
    logic pullup_en_o, port_mode_o, user_update_o, run_idle_o, tap_reset_o, ok;
    logic [3:0] instr_o;
    logic [7:0] user_data_o;
    logic [31:0] dout, din, prev;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int upd_cnt = 0;
    int n0;

    jtp_tap #(.ID_CODE(ID)) dut (.core_clk_i, .nrst_i, .tck_i, .tms_i, .tdi_i, .tdo_o,
        .tdo_oe_o, .test_port_enable_fuse_i(fuse), .pullup_en_o, .port_mode_o, .instr_o,
        .user_data_o, .user_update_o, .run_idle_o, .tap_reset_o);
    jtp_ctl_model ctl (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o),
        .tdo_oe_i(tdo_oe_o));

    // core clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // update pulses counted, too short to poll after a scan
    always @(posedge core_clk_i) begin
        if (user_update_o === 1'b1) upd_cnt <= upd_cnt + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("MISMATCH %0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one bit of bypass, capturing zero
    function automatic logic [7:0] by_exp(input logic [31:0] d);
        return {d[6:0], `JTP_BYPASS_CAPTURE};
    endfunction

    task automatic settle();
        repeat (8) @(posedge core_clk_i);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // main sequence; reset held while tck runs so it reaches the tap
    initial begin
        nrst_i = 1'b0;
        fuse = 1'b1;
        void'($urandom(32'h901a));
        ctl.walk(8'hFF, 5);
        @(posedge core_clk_i);
        nrst_i <= 1'b1;
        ctl.walk(8'hFF, 5);
        settle();
        check({tap_reset_o, instr_o, pullup_en_o, port_mode_o}, 7'b1_0001_10, "rst");
        ctl.walk(8'h00, 1);
        settle();
        check(run_idle_o, 1, "idle");
        ctl.scan(1, `JTP_OP_IDCODE, 4, 1, dout, ok);
        check(dout[3:0], `JTP_IR_CAPTURE, "ir out");
        din = $urandom();
        ctl.scan(0, din, 32, 1, dout, ok);
        check({ok, dout}, {1'b1, ID}, "id");
        ctl.scan(1, `JTP_OP_USERDR, 4, 0, dout, ok);
        prev = `JTP_USR_RESET;
        for (int i = 0; i < 6; i++) begin
            din = (i == 0) ? 32'h0000_00FF : $urandom();
            n0 = upd_cnt;
            ctl.scan(0, din, 8, 1, dout, ok);
            settle();
            check({instr_o, dout[7:0]}, {`JTP_OP_USERDR, prev[7:0]}, "usr cap");
            check({upd_cnt - n0, user_data_o}, {32'd1, din[7:0]}, "usr upd");
            prev = din;
        end
        for (int c = 0; c < 16; c++) begin
            if (c == 1 || c == 2) continue;
            ctl.scan(1, c, 4, 1, dout, ok);
            din = $urandom();
            ctl.scan(0, din, 8, 1, dout, ok);
            check(dout[7:0], by_exp(din), "bypass");
        end
        ctl.scan(1, `JTP_OP_USERDR, 4, 1, dout, ok);
        ctl.walk(8'b1111_1001, 8); // into shift-dr, then five highs
        settle();
        check({tap_reset_o, instr_o}, {1'b1, `JTP_OP_IDCODE}, "tms rst");
        @(posedge core_clk_i);
        fuse <= 1'b0;
        ctl.walk(8'h00, 5);
        settle();
        check({tap_reset_o, port_mode_o, pullup_en_o, run_idle_o}, 4'b1100, "off");
        ctl.scan(1, `JTP_OP_USERDR, 4, 1, dout, ok);
        check(ok, 0, "off drive");
        @(posedge core_clk_i);
        fuse <= 1'b1;
        ctl.walk(8'h1F, 6);
        settle();
        check(run_idle_o, 1, "on again");
        // debugger pulls the system reset mid-run, tck kept running
        @(posedge core_clk_i);
        nrst_i <= 1'b0;
        ctl.walk(8'h00, 5);
        settle();
        check({tap_reset_o, run_idle_o, instr_o, user_data_o},
            {1'b1, 1'b0, `JTP_OP_IDCODE, `JTP_USR_RESET}, "sys rst");
        @(posedge core_clk_i);
        nrst_i <= 1'b1;
        ctl.walk(8'h00, 4);
        settle();
        check(run_idle_o, 1, "idle after rst");
        din = $urandom();
        ctl.scan(0, din, 32, 1, dout, ok);
        check({ok, dout}, {1'b1, ID}, "id after rst");
        tally_and_finish();
    end
endmodule
